// file: hw/csb_pkg.sv
package csb_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0C;
  localparam logic [7:0] LOCK_OFF = 8'h10;
  // Control register fields.
  localparam int CTRL_IRQC_EN_BIT = 0;
  localparam int CTRL_NATIVE_BIT = 1;
  localparam int CTRL_PROBE_ACK_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // Status register fields.
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_SELF_TEST_RUN_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_FPERR_BIT = 3;
  localparam int STAT_PROBE_BIT = 4;
  // Interrupt status fields, same layout in the mask register.
  localparam int IRQ_WARM_BIT = 0;
  localparam int IRQ_LIRQ0_BIT = 1;
  localparam int IRQ_LIRQ1_BIT = 2;
  localparam int IRQ_PROBE_BIT = 3;
  localparam int IRQ_FPERR_BIT = 4;
  localparam int IRQ_W = 5;
  // Lock register: writing 1 starts a locked sequence, writing 0 lets it end when the last transaction completes.
  localparam int LOCK_REQ_BIT = 0;
  // Self test length.
  localparam int CLK_MHZ = 100;
  localparam int SELF_TEST_RUN_TIME_NS = 1000;
  localparam int SELF_TEST_RUN_CYCLES = (SELF_TEST_RUN_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;
  // Execution core sequencing states.
  typedef enum logic [1:0] {
    CSB_ST_RESET = 2'b00,
    CSB_ST_SELF_TEST_RUN = 2'b01,
    CSB_ST_FETCH = 2'b10,
    CSB_ST_WARM = 2'b11
  } csb_state_t;
endpackage

// file: hw/csb_sideband.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - Warm restart clears integer registers, keeps caches.
// - After warm restart, fetch from configured vector.
// - Keep serving snoops during warm restart.
// - Warm restart input is synchronised internally.
// - Warm restart at reset release runs self test.
// - Controller off: irq0 maskable, irq1 nonmaskable.
// - Both local irq pins are synchronised.
// - Controller enabled after reset.
// - Hold atomic lock across whole locked sequence.
// - Error ignore input is synchronised internally.
// - Drive probe ready to the debug tool.
// - Error ignore masks numeric error unless native.
module csb_sideband #(
  parameter int SELF_TEST_RUN_LEN = csb_pkg::SELF_TEST_RUN_CYCLES,
  parameter logic [31:0] RESET_VECTOR = 32'hFFFF_FFF0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic warm_restart_n_i,
  input wire logic [1:0] local_irq_pins_i,
  input wire logic fp_error_ignore_n_i,
  input wire logic probe_request_n_i,
  input wire logic snoop_req_i,
  input wire logic fp_error_pending_i,
  input wire logic lock_seq_last_done_i,
  output logic snoop_ack_o,
  output logic int_regs_clear_o,
  output logic [31:0] fetch_addr_o,
  output logic fetch_en_o,
  output logic self_test_run_active_o,
  output logic maskable_irq_o,
  output logic nonmaskable_irq_o,
  output logic [1:0] local_irq_o,
  output logic fp_exception_o,
  output logic atomic_hold_n_o,
  output logic probe_ready_n_o,
  output logic irq_o,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Synchronised copies of the asynchronous pins.
  csb_sync_if sif();
  logic warm_n_s; // Synchronised warm restart, active low.
  logic fpign_n_s; // Synchronised error ignore, active low.
  logic [1:0] lirq_s; // Synchronised local interrupt pins.
  logic probe_request_n_n_s; // Synchronised probe request.

  assign sif.raw = {probe_request_n_i, fp_error_ignore_n_i, local_irq_pins_i[1],
    local_irq_pins_i[0]};
  assign lirq_s = sif.sync[1:0];
  assign fpign_n_s = sif.sync[2];
  assign probe_request_n_n_s = sif.sync[3];

  // One synchroniser per async pin; interrupt pins idle low, the rest high.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      csb_sync2 #(.RST_VAL(gi >= 2)) u_sync (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .d_i(sif.raw[gi]),
        .q_o(sif.sync[gi])
      );
    end
  endgenerate

  // Warm restart gets its own synchroniser.
  csb_sync2 #(.RST_VAL(1'b1)) u_warm_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i(warm_restart_n_i),
    .q_o(warm_n_s)
  );

  // Register file.
  localparam int IRQ_W_L = csb_pkg::IRQ_W;
  logic [31:0] ctrl_r;
  logic [IRQ_W_L-1:0] irq_stat_r;
  logic [IRQ_W_L-1:0] irq_mask_r;
  logic lock_req_r; // Software request for a locked sequence.

  // Sequencer state.
  csb_pkg::csb_state_t state_r;
  csb_pkg::csb_state_t state_nxt;
  logic [31:0] self_test_run_cnt_r;
  logic [1:0] settle_r; // Edges since reset release, until the synchroniser holds the pin.

  // Controller enable and native error mode come from the control register.
  wire irqc_en = ctrl_r[csb_pkg::CTRL_IRQC_EN_BIT];
  wire native_mode = ctrl_r[csb_pkg::CTRL_NATIVE_BIT];
  wire probe_ack = ctrl_r[csb_pkg::CTRL_PROBE_ACK_BIT];

  // The self test strap is decided only once the synchroniser carries the pin.
  // Its reset value is the idle level, so an earlier look would mask a low pin.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      csb_pkg::CSB_ST_RESET:
        if (settle_r == 2'(csb_pkg::SYNC_STAGES))
          state_nxt = (!warm_n_s) ? csb_pkg::CSB_ST_SELF_TEST_RUN : csb_pkg::CSB_ST_FETCH;
      csb_pkg::CSB_ST_SELF_TEST_RUN:
        if (self_test_run_cnt_r == 32'(SELF_TEST_RUN_LEN - 1))
          state_nxt = csb_pkg::CSB_ST_FETCH;
      csb_pkg::CSB_ST_FETCH:
        if (!warm_n_s)
          state_nxt = csb_pkg::CSB_ST_WARM;
      csb_pkg::CSB_ST_WARM:
        if (warm_n_s)
          state_nxt = csb_pkg::CSB_ST_FETCH;
      default:
        state_nxt = csb_pkg::CSB_ST_RESET;
    endcase
  end

  // State register and self test counter.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= csb_pkg::CSB_ST_RESET;
      self_test_run_cnt_r <= 32'h0000_0000;
      settle_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (settle_r != 2'(csb_pkg::SYNC_STAGES))
        settle_r <= settle_r + 2'h1;
      self_test_run_cnt_r <= (state_r == csb_pkg::CSB_ST_SELF_TEST_RUN) ? self_test_run_cnt_r + 32'h0000_0001
        : 32'h0000_0000;
    end
  end

  // Integer registers clear while warm restart holds; caches untouched.
  assign int_regs_clear_o = (state_r == csb_pkg::CSB_ST_WARM);
  assign fetch_en_o = (state_r == csb_pkg::CSB_ST_FETCH);
  assign fetch_addr_o = RESET_VECTOR;
  assign self_test_run_active_o = (state_r == csb_pkg::CSB_ST_SELF_TEST_RUN);
  // Snoops are answered in every state, warm restart included.
  assign snoop_ack_o = snoop_req_i;

  // Interrupt pin routing: controller mode passes pins, else legacy roles.
  assign local_irq_o = irqc_en ? lirq_s : 2'b00;
  assign maskable_irq_o = !irqc_en && lirq_s[0];
  assign nonmaskable_irq_o = !irqc_en && lirq_s[1];

  // Numeric error raises an exception unless ignored; native mode bypasses pin.
  assign fp_exception_o = fp_error_pending_i && (native_mode || fpign_n_s);

  // Lock held from the request until the last transaction completes.
  logic lock_r;
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lock_r <= 1'b0;
    else if (lock_req_r)
      lock_r <= 1'b1;
    else if (lock_seq_last_done_i)
      lock_r <= 1'b0;
  end
  // Held low continuously so the priority agent cannot take the bus.
  assign atomic_hold_n_o = !(lock_r || lock_req_r);

  // Probe ready follows a pending request once software acknowledges it.
  logic probe_ready_n_r;
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      probe_ready_n_r <= 1'b0;
    else
      probe_ready_n_r <= !probe_request_n_n_s && probe_ack && (state_r == csb_pkg::CSB_ST_FETCH);
  end
  assign probe_ready_n_o = !probe_ready_n_r;

  // Event detection for interrupts: rising edges of the synchronised irq pins and of fp_exception_o, falling edges of warm restart and probe request.
  logic warm_q_r;
  logic [1:0] lirq_q_r;
  logic probe_request_n_q_r;
  logic fpx_q_r;
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      warm_q_r <= 1'b1;
      lirq_q_r <= 2'b00;
      probe_request_n_q_r <= 1'b1;
      fpx_q_r <= 1'b0;
    end
    else
    begin
      warm_q_r <= warm_n_s;
      lirq_q_r <= lirq_s;
      probe_request_n_q_r <= probe_request_n_n_s;
      fpx_q_r <= fp_exception_o;
    end
  end
  wire [IRQ_W_L-1:0] ev = {fp_exception_o && !fpx_q_r, !probe_request_n_n_s && probe_request_n_q_r,
    lirq_s[1] && !lirq_q_r[1], lirq_s[0] && !lirq_q_r[0], !warm_n_s && warm_q_r};

  // AXI4-Lite slave: address and data taken in either order, one at a time.
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_r || aw_hs;
  wire w_have = w_got_r || w_hs;
  wire [7:0] wa = aw_got_r ? awaddr_r : s_axi_awaddr[7:0];
  wire [31:0] wd = w_got_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_got_r ? wstrb_r : s_axi_wstrb;
  wire do_wr = aw_have && w_have;
  wire wr_ctrl = do_wr && (wa == csb_pkg::CTRL_OFF);
  wire wr_istat = do_wr && (wa == csb_pkg::IRQ_STAT_OFF);
  wire wr_imask = do_wr && (wa == csb_pkg::IRQ_MASK_OFF);
  wire wr_lock = do_wr && (wa == csb_pkg::LOCK_OFF);
  wire wr_ok = wr_ctrl || wr_istat || wr_imask || wr_lock ||
    (wa == csb_pkg::STAT_OFF);
  wire wr_hi = ws[0]; // All fields sit in byte 0.

  // Write channel holding registers and response.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (aw_hs)
        awaddr_r <= s_axi_awaddr[7:0];
      if (w_hs)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_got_r <= do_wr ? 1'b0 : aw_have;
      w_got_r <= do_wr ? 1'b0 : w_have;
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10; // Unmapped answers SLVERR.
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Software registers; hardware set beats write-one clear.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_r <= csb_pkg::CTRL_RST;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      lock_req_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && wr_hi)
        ctrl_r <= {29'h0000_0000, wd[2:0]};
      if (wr_imask && wr_hi)
        irq_mask_r <= wd[IRQ_W_L-1:0];
      if (wr_lock && wr_hi)
        lock_req_r <= wd[csb_pkg::LOCK_REQ_BIT];
      irq_stat_r <= (irq_stat_r & ~((wr_istat && wr_hi) ? wd[IRQ_W_L-1:0] : '0)) | ev;
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Read path.
  wire [7:0] ra = s_axi_araddr[7:0];
  wire [31:0] stat_v = {27'h000_0000, !probe_ready_n_o, fp_exception_o,
    !atomic_hold_n_o, self_test_run_active_o, fetch_en_o};
  wire rd_ok = (ra == csb_pkg::CTRL_OFF) || (ra == csb_pkg::STAT_OFF) ||
    (ra == csb_pkg::IRQ_STAT_OFF) || (ra == csb_pkg::IRQ_MASK_OFF) ||
    (ra == csb_pkg::LOCK_OFF);
  wire [31:0] rd_v = (ra == csb_pkg::CTRL_OFF) ? ctrl_r :
    (ra == csb_pkg::STAT_OFF) ? stat_v :
    (ra == csb_pkg::IRQ_STAT_OFF) ? {27'h000_0000, irq_stat_r} :
    (ra == csb_pkg::IRQ_MASK_OFF) ? {27'h000_0000, irq_mask_r} :
    (ra == csb_pkg::LOCK_OFF) ? {31'h0000_0000, lock_r} : 32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;

  // Read answer registered one cycle after the address is taken.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_v;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // csb_sideband

// file: hw/csb_sync2.sv
`timescale 1ns/1ns
// Two flop synchroniser; the first stage feeds only the second.
module csb_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r; // First stage, read only by the second.
  // Both stages reset to the inactive level of the pin.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // csb_sync2

// file: hw/csb_sync_if.sv
`timescale 1ns/1ns
// Bundle of raw asynchronous pins and their synchronised copies.
interface csb_sync_if;
  logic [3:0] raw;
  logic [3:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface // csb_sync_if

// file: test/csb_bus_agent.sv
`timescale 1ns/1ns
// Chipset side: snoops, ends locked sequences, and a priority agent.
module csb_bus_agent (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic snoop_on_i,
  input wire logic end_lock_i,
  input wire logic prio_req_i,
  input wire logic atomic_hold_n_i,
  output logic snoop_req_o,
  output logic lock_seq_last_done_o,
  output logic owned_o
);
  // Ownership waits for the lock to drop, so a locked sequence stays atomic.
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      snoop_req_o <= 1'b0;
      lock_seq_last_done_o <= 1'b0;
      owned_o <= 1'b0;
    end
    else
    begin
      snoop_req_o <= snoop_on_i;
      lock_seq_last_done_o <= end_lock_i;
      owned_o <= prio_req_i && atomic_hold_n_i;
    end
  end
endmodule // csb_bus_agent

// file: test/csb_checker.sv
`timescale 1ns/1ns
// Relates each sideband output except irq_o to the pin or register cause behind it.
module csb_checker #(
  parameter logic [31:0] RESET_VECTOR = 32'hFFFF_FFF0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic warm_restart_n_i,
  input wire logic [1:0] local_irq_pins_i,
  input wire logic fp_error_ignore_n_i,
  input wire logic probe_request_n_i,
  input wire logic snoop_req_i,
  input wire logic fp_error_pending_i,
  input wire logic lock_seq_last_done_i,
  input wire logic snoop_ack_o,
  input wire logic int_regs_clear_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic fetch_en_o,
  input wire logic self_test_run_active_o,
  input wire logic maskable_irq_o,
  input wire logic nonmaskable_irq_o,
  input wire logic [1:0] local_irq_o,
  input wire logic fp_exception_o,
  input wire logic atomic_hold_n_o,
  input wire logic probe_ready_n_o,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Four cycles cover the two synchroniser flops plus the state update.
  sequence s_warm_held;
    (nrst_i && !warm_restart_n_i && !self_test_run_active_o)[*4];
  endsequence
  // Three cycles let the ignore input cross the synchroniser.
  sequence s_err_live;
    (fp_error_pending_i && fp_error_ignore_n_i)[*3];
  endsequence
  a_warm_clear: assert property (s_warm_held |-> int_regs_clear_o && !fetch_en_o)
    else $error("warm restart did not clear the integer registers");
  a_warm_resume: assert property ($fell(int_regs_clear_o) |-> ##[0:3] fetch_en_o)
    else $error("fetch did not resume after warm restart");
  a_fetch_vector: assert property (fetch_en_o |-> fetch_addr_o == RESET_VECTOR)
    else $error("fetch address is not the reset vector");
  a_snoop_live: assert property (snoop_ack_o == snoop_req_i)
    else $error("snoop request not answered");
  a_irq0_sync: assert property ($rose(local_irq_o[0] || maskable_irq_o)
    |-> $past(local_irq_pins_i[0], 2))
    else $error("irq0 output rose without a synchronised pin");
  a_irq1_sync: assert property ($rose(local_irq_o[1] || nonmaskable_irq_o)
    |-> $past(local_irq_pins_i[1], 2))
    else $error("irq1 output rose without a synchronised pin");
  a_irq_route: assert property (!(maskable_irq_o && local_irq_o[0])
    && !(nonmaskable_irq_o && local_irq_o[1]))
    else $error("pin routed to both interrupt roles");
  a_fp_report: assert property (s_err_live |-> fp_exception_o)
    else $error("numeric error not raised");
  a_fp_cause: assert property (fp_exception_o |-> fp_error_pending_i)
    else $error("exception without a pending error");
  a_lock_keep: assert property (!atomic_hold_n_o && !lock_seq_last_done_i
    && !$past(lock_seq_last_done_i) && !(s_axi_wvalid && s_axi_wready)
    && !$past(s_axi_wvalid && s_axi_wready) |=> !atomic_hold_n_o)
    else $error("lock dropped inside a locked sequence");
  a_probe_gate: assert property ($fell(probe_ready_n_o)
    |-> $past(fetch_en_o) && $past(probe_request_n_i, 3) == 1'b0)
    else $error("probe ready without a request");
  a_self_test_run_exit: assert property ($fell(self_test_run_active_o) |-> fetch_en_o)
    else $error("self test did not hand over to fetch");
endmodule // csb_checker
bind csb_sideband csb_checker #(.RESET_VECTOR(RESET_VECTOR)) u_chk (.*);

// file: test/csb_sideband_tb.sv
`timescale 1ns/1ns
// Drives the sideband pins and registers and compares against expected values.
module csb_sideband_tb;
  logic core_clk_i, nrst_i, warm_restart_n_i, fp_error_ignore_n_i, probe_request_n_i;
  logic fp_error_pending_i, snoop_req_i, lock_seq_last_done_i, snoop_on, end_lock, prio, owned;
  logic snoop_ack_o, int_regs_clear_o, fetch_en_o, self_test_run_active_o, maskable_irq_o;
  logic nonmaskable_irq_o, fp_exception_o, atomic_hold_n_o, probe_ready_n_o, irq_o;
  logic [1:0] local_irq_pins_i, local_irq_o, s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] fetch_addr_o, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  int n_fail, num_checks;
  // A short self test keeps the run brief.
  csb_sideband #(.SELF_TEST_RUN_LEN(4)) uut (.*);
  csb_bus_agent u_agent (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .snoop_on_i(snoop_on),
    .end_lock_i(end_lock), .prio_req_i(prio), .atomic_hold_n_i(atomic_hold_n_o),
    .snoop_req_o(snoop_req_i), .lock_seq_last_done_o(lock_seq_last_done_i), .owned_o(owned));
  // Free running 100 MHz clock.
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Write: address and data offered together, each released when taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (ap || wp)
    begin
      @(posedge core_clk_i);
      if (ap && s_axi_awready)
      begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready)
      begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic t_reset();
    axr(csb_pkg::CTRL_OFF);
    chk("ctrl reset", rd, csb_pkg::CTRL_RST);
    axr(8'h40);
    chk("unmapped resp", {30'h0, rs}, 32'h2);
    chk("lock idle", {31'h0, atomic_hold_n_o}, 32'h1);
  endtask
  task automatic t_irq();
    local_irq_pins_i <= 2'b11;
    cyc(4);
    chk("local irq", {30'h0, local_irq_o}, 32'h3);
    chk("legacy irq", {30'h0, nonmaskable_irq_o, maskable_irq_o}, 32'h0);
    axr(csb_pkg::IRQ_STAT_OFF);
    chk("irq stat", rd, 32'h6);
    axw(csb_pkg::IRQ_MASK_OFF, 32'h6);
    chk("irq on", {31'h0, irq_o}, 32'h1);
    axw(csb_pkg::IRQ_MASK_OFF, 32'h0);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    axw(csb_pkg::IRQ_STAT_OFF, 32'h6);
    axr(csb_pkg::IRQ_STAT_OFF);
    chk("irq cleared", rd, 32'h0);
    axw(csb_pkg::CTRL_OFF, 32'h0);
    cyc(2);
    chk("legacy on", {30'h0, nonmaskable_irq_o, maskable_irq_o}, 32'h3);
    chk("local off", {30'h0, local_irq_o}, 32'h0);
    local_irq_pins_i <= 2'b00;
    cyc(4);
    chk("legacy low", {30'h0, nonmaskable_irq_o, maskable_irq_o}, 32'h0);
  endtask
  task automatic t_warm();
    snoop_on <= 1'b1;
    warm_restart_n_i <= 1'b0;
    cyc(8);
    chk("regs clear", {30'h0, int_regs_clear_o, fetch_en_o}, 32'h2);
    chk("snoop ack", {31'h0, snoop_ack_o}, 32'h1);
    warm_restart_n_i <= 1'b1;
    snoop_on <= 1'b0;
    cyc(6);
    chk("fetch again", {30'h0, int_regs_clear_o, fetch_en_o}, 32'h1);
    chk("vector", fetch_addr_o, 32'hFFFF_FFF0);
    axr(csb_pkg::IRQ_STAT_OFF);
    chk("warm event", rd, 32'h1);
    axw(csb_pkg::IRQ_STAT_OFF, 32'h1);
  endtask
  task automatic t_fp();
    fp_error_pending_i <= 1'b1;
    cyc(4);
    chk("error ignored", {31'h0, fp_exception_o}, 32'h0);
    fp_error_ignore_n_i <= 1'b1;
    cyc(4);
    chk("error raised", {31'h0, fp_exception_o}, 32'h1);
    fp_error_ignore_n_i <= 1'b0;
    axw(csb_pkg::CTRL_OFF, 32'h2);
    cyc(4);
    chk("native mode", {31'h0, fp_exception_o}, 32'h1);
    fp_error_pending_i <= 1'b0;
    axr(csb_pkg::IRQ_STAT_OFF);
    chk("error event", rd, 32'h10);
  endtask
  task automatic t_lock();
    prio <= 1'b1;
    axw(csb_pkg::LOCK_OFF, 32'h1);
    cyc(2);
    chk("lock held", {30'h0, atomic_hold_n_o, owned}, 32'h0);
    axr(csb_pkg::STAT_OFF);
    chk("lock status", rd, 32'h5);
    axw(csb_pkg::LOCK_OFF, 32'h0);
    end_lock <= 1'b1;
    cyc(1);
    end_lock <= 1'b0;
    cyc(3);
    chk("lock freed", {30'h0, atomic_hold_n_o, owned}, 32'h3);
  endtask
  task automatic t_probe();
    probe_request_n_i <= 1'b0;
    axw(csb_pkg::CTRL_OFF, 32'h4);
    cyc(5);
    chk("probe ready", {31'h0, probe_ready_n_o}, 32'h0);
    axr(csb_pkg::IRQ_STAT_OFF);
    chk("probe event", rd, 32'h18);
  endtask
  // Mid-run reset with warm restart held low through release must run self test.
  task automatic t_self_test_run();
    warm_restart_n_i <= 1'b0;
    cyc(2);
    nrst_i <= 1'b0;
    cyc(2);
    nrst_i <= 1'b1;
    cyc(4);
    chk("self_test_run run", {31'h0, self_test_run_active_o}, 32'h1);
    warm_restart_n_i <= 1'b1;
    cyc(12);
    chk("self_test_run done", {30'h0, self_test_run_active_o, fetch_en_o}, 32'h1);
    axr(csb_pkg::CTRL_OFF);
    chk("ctrl again", rd, csb_pkg::CTRL_RST);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog sized well beyond the fewer than two hundred cycles the tests need.
  initial
  begin
    #100000;
    n_fail++;
    summarize();
  end
  initial
  begin
    {nrst_i, fp_error_pending_i, snoop_on, end_lock, prio, local_irq_pins_i} = '0;
    {warm_restart_n_i, fp_error_ignore_n_i, probe_request_n_i} = 3'b101;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    n_fail = 0;
    num_checks = 0;
    cyc(20);
    nrst_i <= 1'b1;
    cyc(2);
    t_reset();
    t_irq();
    t_warm();
    t_fp();
    t_lock();
    t_probe();
    t_self_test_run();
    summarize();
  end
endmodule // csb_sideband_tb
